/* src/irb_pkg.sv */
// constants shared by the infrared remote register bank
package irb_pkg;
  // register byte addresses (16-bit registers, halfword aligned)
  localparam logic [15:0] ADDR_CLOCK_CTRL  = 16'h5320;
  localparam logic [15:0] ADDR_COUNTER_CTL = 16'h5322;
  localparam logic [15:0] ADDR_COUNTER_VAL = 16'h5324;
  localparam logic [15:0] ADDR_PULSE_LEN   = 16'h5326;
  localparam logic [15:0] ADDR_BIT_LEN     = 16'h5328;
  localparam logic [15:0] ADDR_STATUS      = 16'h532A;
  localparam logic [15:0] ADDR_INT_ENABLE  = 16'h532C;
  localparam logic [15:0] ADDR_CARRIER     = 16'h5330;
  localparam logic [15:0] ADDR_CARRIER_CTL = 16'h5332;

  // clock control fields
  localparam int CLK_RUN_DEBUG_BIT = 8;
  localparam int CLK_DIV_LSB       = 4;
  localparam int CLK_SRC_LSB       = 0;

  // counter control fields
  localparam int CTL_PRESET_BIT  = 9;
  localparam int CTL_RUN_BIT     = 8;
  localparam int CTL_INVERT_BIT  = 4;
  localparam int CTL_BUFFER_ENABLE_BIT   = 3;
  localparam int CTL_REPEAT_BIT  = 2;
  localparam int CTL_CRST_BIT    = 1;
  localparam int CTL_MODULE_ENABLE_BIT   = 0;

  // status and flag fields
  localparam int STA_RUNNING_BIT = 10;
  localparam int STA_BITBSY_BIT  = 9;
  localparam int STA_PULBSY_BIT  = 8;
  localparam int STA_BITIF_BIT   = 1;
  localparam int STA_PULIF_BIT   = 0;

  // carrier fields
  localparam int CAR_DUTY_LSB    = 8;
  localparam int CAR_EN_BIT      = 0;

  // values after reset
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [1:0]  FLAGS_NONE = 2'h0;
endpackage

/* src/irb_flag_pair.sv */
// sticky event flags with write-one-clear and bulk clear
module irb_flag_pair
  import irb_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [1:0] setEvent,
  input  wire logic [1:0] clearOnes,
  input  wire logic       clearAll,
  output logic      [1:0] flags
);
  typedef struct packed {
    logic [1:0] flags;
  } irb_flag_s;

  irb_flag_s state;
  irb_flag_s next_state;

  // a set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    next_state = state;
    if (clearAll) begin
      next_state.flags = FLAGS_NONE;
    end else begin
      next_state.flags = state.flags & ~clearOnes;
    end
    next_state.flags = next_state.flags | setEvent;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state.flags <= FLAGS_NONE;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
endmodule

/* src/irb_bit_counter.sv */
// 16-bit data bit counter with synchronous clear
module irb_bit_counter
  import irb_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clear,
  input  wire logic             advance,
  output logic      [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } irb_cnt_s;

  irb_cnt_s state;
  irb_cnt_s next_state;

  // clear beats advance: the reset command restarts the count
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.count = '0;
    end else if (advance) begin
      next_state.count = state.count + WIDTH'(1);
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state.count <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;
endmodule

/* src/irb_register_bank.sv */
// register bank of the infrared remote transmitter
//
// The plain strobed port was decided locally.
module irb_register_bank
  import irb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWriteData,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  output logic      [15:0] busReadData,
  input  wire logic        bitDoneEvent,
  input  wire logic        pulseDoneEvent,
  input  wire logic        bitAdvance,
  input  wire logic        countRunning,
  input  wire logic        bitLengthPending,
  input  wire logic        pulseLengthPending,
  output logic             irq,
  output logic             moduleEnable,
  output logic             counterRun,
  output logic             counterPreset,
  output logic             counterResetPulse,
  output logic             bufferEnable,
  output logic             repeatMode,
  output logic             outputInvert,
  output logic      [15:0] pulseLengthValue,
  output logic      [15:0] bitLengthValue,
  output logic      [7:0]  carrierDuty,
  output logic      [7:0]  carrierPeriod,
  output logic             carrierEnable,
  output logic      [3:0]  clockDivider,
  output logic      [1:0]  clockSource,
  output logic             runInDebug
);
  // architectural state of the bank, apart from the bit counter and the sticky flags
  typedef struct packed {
    logic [15:0] readData;      // read answer, valid one cycle
    logic        runDebug;      // keep running while halted
    logic [3:0]  clock_divider;        // peripheral clock divider
    logic [1:0]  clock_source;        // peripheral clock source
    logic        preset;        // counter preset
    logic        run;           // counter run
    logic        invert;        // output polarity
    logic        buffer_enable;         // buffered length update
    logic        repeatMd;      // repeat/one-shot mode
    logic        module_enable;         // module enable
    logic        crstPulse;     // registered reset command
    logic [15:0] pulseLen;      // active pulse length
    logic [15:0] bitLen;        // data bit length
    logic        running;       // registered running status
    logic        bitBusy;       // bit length update pending
    logic        pulseBusy;     // pulse length update pending
    logic [1:0]  intEn;         // interrupt enables
    logic [7:0]  duty;          // carrier high width
    logic [7:0]  period;        // carrier period
    logic        carEn;         // carrier modulation enable
    logic        irqOut;        // interrupt line
  } irb_bank_s;

  irb_bank_s   state;
  irb_bank_s   next_state;
  logic [15:0] countValue;      // live bit counter
  logic [1:0]  flagBits;        // sticky interrupt flags
  logic        crstWrite;       // reset command written this cycle
  logic        wrCtl;           // write to counter control
  logic        wrFlags;         // write to status register
  logic [1:0]  flagClear;       // write-one-clear mask

  // address hit helper
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // the reset command is a write-only strobe inside the control word
  assign wrCtl     = busWrite && hit(busAddr, ADDR_COUNTER_CTL);
  assign crstWrite = wrCtl && busWriteData[CTL_CRST_BIT];
  assign wrFlags   = busWrite && hit(busAddr, ADDR_STATUS);
  assign flagClear = wrFlags ? busWriteData[STA_BITIF_BIT:STA_PULIF_BIT]
                             : FLAGS_NONE;

  // counter, cleared by the reset command
  irb_bit_counter #(
    .WIDTH (16)
  ) u_counter (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clear   (crstWrite),
    .advance (bitAdvance && state.run && !crstWrite),
    .count   (countValue)
  );

  // sticky flags, cleared by write-one or by the reset command
  irb_flag_pair u_flags (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .setEvent  ({bitDoneEvent, pulseDoneEvent}),
    .clearOnes (flagClear),
    .clearAll  (crstWrite),
    .flags     (flagBits)
  );

  // next-state logic: writes, status tracking, read mux
  always_comb begin
    next_state = state;
    next_state.readData  = 16'h0000;
    next_state.crstPulse = crstWrite;

    // status inputs come from the same clock domain, no synchroniser
    // the running bit drops on the reset command even if the core
    // still reports activity in that cycle
    next_state.running = countRunning && !crstWrite;
    // busy bits only mean anything while buffering is on
    next_state.bitBusy   = state.buffer_enable && bitLengthPending;
    next_state.pulseBusy = state.buffer_enable && pulseLengthPending;

    if (busWrite) begin
      case (busAddr)
        ADDR_CLOCK_CTRL: begin
          next_state.runDebug = busWriteData[CLK_RUN_DEBUG_BIT];
          next_state.clock_divider   = busWriteData[CLK_DIV_LSB +: 4];
          next_state.clock_source   = busWriteData[CLK_SRC_LSB +: 2];
        end
        ADDR_COUNTER_CTL: begin
          next_state.preset   = busWriteData[CTL_PRESET_BIT];
          next_state.run      = busWriteData[CTL_RUN_BIT];
          next_state.invert   = busWriteData[CTL_INVERT_BIT];
          next_state.buffer_enable    = busWriteData[CTL_BUFFER_ENABLE_BIT];
          next_state.repeatMd = busWriteData[CTL_REPEAT_BIT];
          next_state.module_enable    = busWriteData[CTL_MODULE_ENABLE_BIT];
        end
        ADDR_PULSE_LEN: begin
          // ignored while the module is disabled
          if (state.module_enable) begin
            next_state.pulseLen = busWriteData;
          end
        end
        ADDR_BIT_LEN: begin
          // ignored while the module is disabled
          if (state.module_enable) begin
            next_state.bitLen = busWriteData;
          end
        end
        ADDR_INT_ENABLE: begin
          next_state.intEn = busWriteData[STA_BITIF_BIT:STA_PULIF_BIT];
        end
        ADDR_CARRIER: begin
          next_state.duty   = busWriteData[CAR_DUTY_LSB +: 8];
          next_state.period = busWriteData[7:0];
        end
        ADDR_CARRIER_CTL: begin
          next_state.carEn = busWriteData[CAR_EN_BIT];
        end
        default: begin
          // unmapped or read-only: no register changes; status writes clear flags via flagClear
        end
      endcase
    end

    // reset command overrides the preset and run bits just written
    if (crstWrite) begin
      next_state.preset = 1'b0;
      next_state.run    = 1'b0;
    end

    if (busRead) begin
      case (busAddr)
        ADDR_CLOCK_CTRL: begin
          next_state.readData[CLK_RUN_DEBUG_BIT]  = state.runDebug;
          next_state.readData[CLK_DIV_LSB +: 4]   = state.clock_divider;
          next_state.readData[CLK_SRC_LSB +: 2]   = state.clock_source;
        end
        ADDR_COUNTER_CTL: begin
          // the reset command bit always reads zero
          next_state.readData[CTL_PRESET_BIT] = state.preset;
          next_state.readData[CTL_RUN_BIT]    = state.run;
          next_state.readData[CTL_INVERT_BIT] = state.invert;
          next_state.readData[CTL_BUFFER_ENABLE_BIT]  = state.buffer_enable;
          next_state.readData[CTL_REPEAT_BIT] = state.repeatMd;
          next_state.readData[CTL_MODULE_ENABLE_BIT]  = state.module_enable;
        end
        ADDR_COUNTER_VAL: begin
          next_state.readData = countValue;
        end
        ADDR_PULSE_LEN: begin
          next_state.readData = state.pulseLen;
        end
        ADDR_BIT_LEN: begin
          next_state.readData = state.bitLen;
        end
        ADDR_STATUS: begin
          next_state.readData[STA_RUNNING_BIT] = state.running;
          next_state.readData[STA_BITBSY_BIT]  = state.bitBusy;
          next_state.readData[STA_PULBSY_BIT]  = state.pulseBusy;
          next_state.readData[STA_BITIF_BIT:STA_PULIF_BIT] = flagBits;
        end
        ADDR_INT_ENABLE: begin
          next_state.readData[STA_BITIF_BIT:STA_PULIF_BIT] = state.intEn;
        end
        ADDR_CARRIER: begin
          next_state.readData = {state.duty, state.period};
        end
        ADDR_CARRIER_CTL: begin
          next_state.readData[CAR_EN_BIT] = state.carEn;
        end
        default: begin
          // unmapped addresses read as zero
          next_state.readData = 16'h0000;
        end
      endcase
    end

    // level interrupt from registered flags; follows flags by one cycle
    next_state.irqOut = |(flagBits & state.intEn);
  end

  // state register, everything cleared by the synchronous reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign busReadData       = state.readData;
  assign irq               = state.irqOut;
  assign moduleEnable      = state.module_enable;
  assign counterRun        = state.run;
  assign counterPreset     = state.preset;
  assign counterResetPulse = state.crstPulse;
  assign bufferEnable      = state.buffer_enable;
  assign repeatMode        = state.repeatMd;
  assign outputInvert      = state.invert;
  assign pulseLengthValue  = state.pulseLen;
  assign bitLengthValue    = state.bitLen;
  assign carrierDuty       = state.duty;
  assign carrierPeriod     = state.period;
  assign carrierEnable     = state.carEn;
  assign clockDivider      = state.clock_divider;
  assign clockSource       = state.clock_source;
  assign runInDebug        = state.runDebug;
endmodule

/* testbench/irb_tx_model.sv */
// stand-in for the waveform engine that feeds the bank its events
module irb_tx_model (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic counterRun,     // bank lets the engine count
  output logic      bitAdvance,     // one data bit sent
  output logic      bitDoneEvent,   // end of a data bit
  output logic      pulseDoneEvent, // end of the active pulse
  output logic      countRunning    // engine busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase; // place inside a four-cycle data bit

  initial {phase, bitAdvance, bitDoneEvent, pulseDoneEvent,
    countRunning} = '0;
  // engine stands still unless the counter runs; busy lags one cycle,
  // so the bank must mask the stale busy right after a reset command
  always @(posedge sys_clk) begin
    phase <= (reset || !counterRun) ? 2'h0 : phase + 2'h1;
    countRunning <= !reset && counterRun;
    pulseDoneEvent <= !reset && counterRun && phase == 2'h1;
    bitDoneEvent <= !reset && counterRun && phase == 2'h3;
    bitAdvance <= !reset && counterRun && phase == 2'h3;
  end
endmodule

/* testbench/irb_checker_assertions.sv */
// checker for the register bank ports, bound into the bank
module irb_checker
  import irb_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWriteData,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [15:0] busReadData,
  input wire logic        bitDoneEvent,
  input wire logic        pulseDoneEvent,
  input wire logic        irq,
  input wire logic        moduleEnable,
  input wire logic        counterRun,
  input wire logic        counterPreset,
  input wire logic        bufferEnable,
  input wire logic [15:0] pulseLengthValue,
  input wire logic [15:0] bitLengthValue
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic crst;   // reset command written, no flag event beside it
  logic stRd;   // status register read

  assign crst = busWrite && busAddr == ADDR_COUNTER_CTL &&
    busWriteData[CTL_CRST_BIT] && !bitDoneEvent && !pulseDoneEvent;
  assign stRd = busRead && busAddr == ADDR_STATUS;

  crst_stops_a: assert property (
    crst |=> !counterRun && !counterPreset)
    else $error("counter still armed");
  cnt_clear_a: assert property (
    crst ##1 (busRead && busAddr == ADDR_COUNTER_VAL)
    |=> busReadData == 16'h0000) else $error("count not cleared");
  run_clear_a: assert property (
    crst ##1 stRd |=> !busReadData[STA_RUNNING_BIT])
    else $error("running status kept");
  pulse_gate_a: assert property (
    busWrite && busAddr == ADDR_PULSE_LEN |=> pulseLengthValue ==
    ($past(moduleEnable) ? $past(busWriteData) : $past(pulseLengthValue)))
    else $error("pulse length gating wrong");
  bit_gate_a: assert property (
    busWrite && busAddr == ADDR_BIT_LEN && !moduleEnable
    |=> $stable(bitLengthValue)) else $error("bit length taken");
  busy_hidden_a: assert property (
    stRd && !bufferEnable && !$past(bufferEnable)
    |=> busReadData[9:8] == 2'b00) else $error("busy bits shown");
  flag_crst_a: assert property (
    crst ##1 stRd |=> busReadData[1:0] == 2'b00)
    else $error("flags not cleared");
  irq_drop_a: assert property (
    crst |-> ##2 !irq) else $error("interrupt held");
endmodule

bind irb_register_bank irb_checker u_chk (
  .sys_clk(sys_clk), .reset(reset), .busAddr(busAddr),
  .busWriteData(busWriteData), .busWrite(busWrite), .busRead(busRead),
  .busReadData(busReadData), .bitDoneEvent(bitDoneEvent),
  .pulseDoneEvent(pulseDoneEvent), .irq(irq),
  .moduleEnable(moduleEnable), .counterRun(counterRun),
  .counterPreset(counterPreset), .bufferEnable(bufferEnable),
  .pulseLengthValue(pulseLengthValue), .bitLengthValue(bitLengthValue));

/* testbench/tb_top.sv */
// self-checking bench for the infrared remote register bank
module tb_top
  import irb_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic [15:0] busWriteData = 16'h0000;
  logic        busWrite = 1'b0;
  logic        busRead = 1'b0;
  logic        pend = 1'b0;  // engine reports both lengths pending
  logic [15:0] busReadData;
  logic        bitAdvance, bitDoneEvent, pulseDoneEvent, countRunning;
  logic        irq, counterRun;
  logic        moduleEnable, counterPreset, counterResetPulse;
  logic        bufferEnable, repeatMode, outputInvert, carrierEnable;
  logic        runInDebug;
  logic [15:0] pulseLengthValue, bitLengthValue;
  logic [7:0]  carrierDuty, carrierPeriod;
  logic [3:0]  clockDivider;
  logic [1:0]  clockSource;
  int          miscompares = 0;
  int          numChecks = 0;
  int          tally = 0;    // bits finished while counting

  irb_register_bank DUT (.sys_clk(sys_clk), .reset(reset),
    .busAddr(busAddr), .busWriteData(busWriteData), .busWrite(busWrite),
    .busRead(busRead), .busReadData(busReadData),
    .bitDoneEvent(bitDoneEvent), .pulseDoneEvent(pulseDoneEvent),
    .bitAdvance(bitAdvance), .countRunning(countRunning),
    .bitLengthPending(pend), .pulseLengthPending(pend), .irq(irq),
    .moduleEnable(moduleEnable), .counterRun(counterRun),
    .counterPreset(counterPreset),
    .counterResetPulse(counterResetPulse), .bufferEnable(bufferEnable),
    .repeatMode(repeatMode), .outputInvert(outputInvert),
    .pulseLengthValue(pulseLengthValue),
    .bitLengthValue(bitLengthValue), .carrierDuty(carrierDuty),
    .carrierPeriod(carrierPeriod), .carrierEnable(carrierEnable),
    .clockDivider(clockDivider), .clockSource(clockSource),
    .runInDebug(runInDebug));
  irb_tx_model u_tx (.sys_clk(sys_clk), .reset(reset),
    .counterRun(counterRun), .bitAdvance(bitAdvance),
    .bitDoneEvent(bitDoneEvent), .pulseDoneEvent(pulseDoneEvent),
    .countRunning(countRunning));

  initial forever #12.5 sys_clk = ~sys_clk;
  // count bits as the bank should: only while the run bit is set
  always @(posedge sys_clk)
    if (!reset && bitAdvance === 1'b1 && counterRun === 1'b1) tally++;

  task automatic chk(input string n, input logic [15:0] e, g);
    numChecks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle write; strobe stays up so a next access may follow at once
  task automatic wr(input logic [15:0] a, d);
    busAddr <= a;
    busWriteData <= d;
    busWrite <= 1'b1;
    busRead <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input string n, input logic [15:0] a, e, m);
    busAddr <= a;
    busRead <= 1'b1;
    busWrite <= 1'b0;
    @(posedge sys_clk);
    busRead <= 1'b0;
    @(negedge sys_clk);
    chk(n, e, busReadData & m);
    @(posedge sys_clk);
  endtask
  task automatic cyc(input int n);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic ci(input logic e);
    cyc(2);
    @(negedge sys_clk);
    chk("irq", {15'h0, e}, {15'h0, irq});
    @(posedge sys_clk);
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // every register clears on reset; the unmapped slot reads zero
  task automatic tReset;
    logic [15:0] r [10] = '{ADDR_CLOCK_CTRL, ADDR_COUNTER_CTL,
      ADDR_COUNTER_VAL, ADDR_PULSE_LEN, ADDR_BIT_LEN, ADDR_STATUS,
      ADDR_INT_ENABLE, ADDR_CARRIER, ADDR_CARRIER_CTL, 16'h5334};
    foreach (r[i]) rdc("reset", r[i], 16'h0000, 16'hFFFF);
  endtask
  // lengths refuse writes while the module is off; count is read-only
  task automatic tLengths;
    wr(ADDR_PULSE_LEN, 16'h1234);
    rdc("apl off", ADDR_PULSE_LEN, 16'h0000, 16'hFFFF);
    wr(ADDR_BIT_LEN, 16'h4321);
    rdc("dbl off", ADDR_BIT_LEN, 16'h0000, 16'hFFFF);
    wr(ADDR_COUNTER_CTL, 16'h0001);
    wr(ADDR_PULSE_LEN, 16'hA5C3);
    wr(ADDR_BIT_LEN, 16'h5A3C);
    wr(ADDR_COUNTER_VAL, 16'hFFFF);
    rdc("apl", ADDR_PULSE_LEN, 16'hA5C3, 16'hFFFF);
    rdc("dbl", ADDR_BIT_LEN, 16'h5A3C, 16'hFFFF);
    chk("apl pins", 16'hA5C3, pulseLengthValue);
    chk("dbl pins", 16'h5A3C, bitLengthValue);
    rdc("cnt ro", ADDR_COUNTER_VAL, 16'h0000, 16'hFFFF);
  endtask
  // run, count, raise and mask the interrupt, then reset by command
  task automatic tCount;
    wr(ADDR_COUNTER_CTL, 16'h0101);
    cyc(20);
    rdc("run sts", ADDR_STATUS, 16'h0403, 16'hFFFF);
    wr(ADDR_COUNTER_CTL, 16'h0001);
    cyc(3);
    rdc("count", ADDR_COUNTER_VAL, tally[15:0], 16'hFFFF);
    wr(ADDR_INT_ENABLE, 16'h0003);
    ci(1'b1);
    wr(ADDR_STATUS, 16'h0001);
    rdc("w1c", ADDR_STATUS, 16'h0002, 16'hFFFF);
    wr(ADDR_INT_ENABLE, 16'h0001);
    ci(1'b0);
    wr(ADDR_INT_ENABLE, 16'h0002);
    ci(1'b1);
    wr(ADDR_COUNTER_CTL, 16'h0003);
    rdc("crst sts", ADDR_STATUS, 16'h0000, 16'hFFFF);
    ci(1'b0);
    wr(ADDR_COUNTER_CTL, 16'h0101);
    cyc(6);
    wr(ADDR_COUNTER_CTL, 16'h0303);
    rdc("crst run", ADDR_STATUS, 16'h0000, 16'h0700);
    rdc("crst ctl", ADDR_COUNTER_CTL, 16'h0001, 16'hFFFF);
    rdc("crst cnt", ADDR_COUNTER_VAL, 16'h0000, 16'hFFFF);
    // count again, stop, let the engine settle, then clear by command
    wr(ADDR_COUNTER_CTL, 16'h0101);
    cyc(6);
    wr(ADDR_COUNTER_CTL, 16'h0001);
    cyc(2);
    wr(ADDR_COUNTER_CTL, 16'h0003);
    rdc("crst cnt2", ADDR_COUNTER_VAL, 16'h0000, 16'hFFFF);
  endtask
  // busy bits only show once buffering is switched on
  task automatic tBusy;
    wr(ADDR_STATUS, 16'h0003);
    pend <= 1'b1;
    cyc(3);
    rdc("busy off", ADDR_STATUS, 16'h0000, 16'hFFFF);
    wr(ADDR_COUNTER_CTL, 16'h0009);
    cyc(2);
    rdc("busy on", ADDR_STATUS, 16'h0300, 16'hFFFF);
  endtask
  // plain settings read back on the bus and on the pins
  task automatic tRegs;
    wr(ADDR_CLOCK_CTRL, 16'hFFFF);
    wr(ADDR_CARRIER, 16'hA55A);
    wr(ADDR_CARRIER_CTL, 16'hFFFF);
    wr(ADDR_INT_ENABLE, 16'hFFFF);
    wr(ADDR_COUNTER_CTL, 16'h021D);
    rdc("clk", ADDR_CLOCK_CTRL, 16'h01F3, 16'hFFFF);
    rdc("carrier", ADDR_CARRIER, 16'hA55A, 16'hFFFF);
    rdc("car ctl", ADDR_CARRIER_CTL, 16'h0001, 16'hFFFF);
    rdc("inte", ADDR_INT_ENABLE, 16'h0003, 16'hFFFF);
    rdc("ctl", ADDR_COUNTER_CTL, 16'h021D, 16'hFFFF);
    chk("clk pins", 16'h01F3,
      {7'h0, runInDebug, clockDivider, 2'h0, clockSource});
    chk("car pins", 16'hA55A, {carrierDuty, carrierPeriod});
    chk("car en", 16'h0001, {15'h0, carrierEnable});
    chk("ctl pins", 16'h021D, {6'h0, counterPreset, counterRun, 3'h0,
      outputInvert, bufferEnable, repeatMode, counterResetPulse,
      moduleEnable});
    // the command pulse stands for one cycle after the write
    wr(ADDR_COUNTER_CTL, 16'h0003);
    busWrite <= 1'b0;
    @(negedge sys_clk);
    chk("crst pins", 16'h0002, {14'h0, counterResetPulse,
      counterPreset});
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    tReset;
    tLengths;
    tCount;
    tBusy;
    tRegs;
    cyc(2);
    endOfTest;
  end
  // a hang is cut short and counted as a mismatch
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    endOfTest;
  end
endmodule
